// [verilog/xfc_cmd_engine.sv]
// xspi command decoder: fast reads, write enable latch, register access
`timescale 1ns/10ps
module xfc_cmd_engine #(
    parameter int         DUMMY_CYC = xfc_pkg::DUMMY_DEF,
    parameter int         TW_CYC    = xfc_pkg::TW_CYC,
    parameter int         NONVOLATILE_CONFIG_WRITE_TIME_CYC = xfc_pkg::NONVOLATILE_CONFIG_WRITE_TIME_CYC,
    parameter logic [7:0] NV_RSVD   = xfc_pkg::NV_RSVD_DEF,
    parameter logic [7:0] V_RSVD    = xfc_pkg::V_RSVD_DEF
) (
    input  wire logic        mclk,
    input  wire logic        rst_b,
    input  wire logic        select_n,
    input  wire logic        serial_clk,
    input  wire logic        serial_in_line,
    input  wire logic [7:0]  octal_in,
    output logic      [7:0]  octal_out,
    output logic      [7:0]  octal_oe,
    output logic             serial_out_line,
    output logic             serial_out_oe,
    input  wire logic        octal_mode,
    input  wire logic        ddr_mode,
    input  wire logic        addr4_mode,
    input  wire logic [5:0]  status_hi,
    input  wire logic [7:0]  flag_in,
    input  wire logic [7:0]  nv_cfg,
    input  wire logic [7:0]  v_cfg,
    input  wire logic        protect_err_set,
    input  wire logic [7:0]  rd_data,
    output logic      [31:0] rd_addr,
    output logic             rd_req,
    output logic             wel,
    output logic             wip,
    output logic             prot_err,
    output logic             reg_wr_stb,
    output logic             reg_wr_nv,
    output logic      [15:0] reg_wr_data
);

    // ****************************************
    // decode helpers
    // ****************************************
    function automatic logic is_fast(input logic [7:0] op);
        is_fast = op == xfc_pkg::OP_FR || op == xfc_pkg::OP_FR4 ||
                  op == xfc_pkg::OP_OOFR || op == xfc_pkg::OP_OOFR4 ||
                  op == xfc_pkg::OP_OIOFR || op == xfc_pkg::OP_OIOFR4 ||
                  op == xfc_pkg::OP_DOOFR || op == xfc_pkg::OP_DOIOFR;
    endfunction

    function automatic logic is_addr4(input logic [7:0] op);
        is_addr4 = op == xfc_pkg::OP_RD4 || op == xfc_pkg::OP_FR4 ||
                   op == xfc_pkg::OP_OOFR4 || op == xfc_pkg::OP_OIOFR4 ||
                   op == xfc_pkg::OP_DOIOFR;
    endfunction

    function automatic logic addr_wide(input logic [7:0] op);
        addr_wide = op == xfc_pkg::OP_OIOFR || op == xfc_pkg::OP_OIOFR4 ||
                    op == xfc_pkg::OP_DOIOFR;
    endfunction

    function automatic logic out_ddr(input logic [7:0] op);
        out_ddr = op == xfc_pkg::OP_DOOFR || op == xfc_pkg::OP_DOIOFR;
    endfunction

    function automatic logic out_wide(input logic [7:0] op);
        out_wide = out_ddr(op) || op == xfc_pkg::OP_OOFR ||
                   op == xfc_pkg::OP_OOFR4;
    endfunction

    // ****************************************
    // pin synchronisers and edge detect
    // ****************************************
    logic [10:0]        sync_w;
    logic               sel_s;
    logic               sck_s;
    logic               si_s;
    logic [7:0]         oct_s;
    logic               sel_p_q;
    logic               sck_p_q;
    logic               sck_rise;
    logic               sck_fall;
    logic               sel_rise;

    xfc_sync #(
        .WIDTH   (11),
        .RST_VAL (11'h400)
    ) u_sync (
        .clk   (mclk),
        .rst_b (rst_b),
        .din   ({select_n, serial_clk, serial_in_line, octal_in}),
        .dout  (sync_w)
    );

    assign sel_s    = sync_w[10];
    assign sck_s    = sync_w[9];
    assign si_s     = sync_w[8];
    assign oct_s    = sync_w[7:0];
    assign sck_rise = sck_s & ~sck_p_q;
    assign sck_fall = ~sck_s & sck_p_q;
    assign sel_rise = sel_s & ~sel_p_q;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sel_p_q <= 1'b1;
            sck_p_q <= 1'b0;
        end else begin
            sel_p_q <= sel_s;
            sck_p_q <= sck_s;
        end
    end

    // ****************************************
    // lane width and data rate per phase
    // ****************************************
    xfc_pkg::xfc_state_e st_q;
    logic [7:0]         op_q;
    logic [31:0]        sh_q;
    logic [5:0]         cnt_q;
    logic               oct_ddr;
    logic               wide_in;
    logic               ddr_in;
    logic               wide_o;
    logic               ddr_o;
    logic               smp_ev;
    logic               drv_ev;
    logic [31:0]        sh_d;
    logic [5:0]         cnt_d;
    logic [5:0]         addr_bits;

    assign oct_ddr = octal_mode & ddr_mode;
    assign wide_in = octal_mode |
                     (st_q == xfc_pkg::ST_ADDR && addr_wide(op_q));
    assign ddr_in  = oct_ddr |
                     (st_q == xfc_pkg::ST_ADDR && out_ddr(op_q));
    assign wide_o  = octal_mode | out_wide(op_q);
    assign ddr_o   = oct_ddr | out_ddr(op_q);
    assign smp_ev  = sck_rise | (ddr_in & sck_fall);
    assign drv_ev  = sck_fall | (ddr_o & sck_rise);
    assign sh_d    = wide_in ? {sh_q[23:0], oct_s} : {sh_q[30:0], si_s};
    assign cnt_d   = cnt_q + (wide_in ? xfc_pkg::BYTE_BITS : 6'h01);
    assign addr_bits = (addr4_mode || is_addr4(op_q)) ?
                       xfc_pkg::ADDR4_BITS : xfc_pkg::ADDR3_BITS;

    // ****************************************
    // command sequencer
    // ****************************************
    logic [7:0]         dcnt_q;
    logic [1:0]         nbyte_q;
    logic [15:0]        wdat_q;
    logic               shifting;

    assign shifting = smp_ev && (st_q == xfc_pkg::ST_CMD ||
                                 st_q == xfc_pkg::ST_ADDR ||
                                 st_q == xfc_pkg::ST_DIN);

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            st_q  <= xfc_pkg::ST_IDLE;
            op_q  <= 8'h00;
            sh_q  <= 32'h0000_0000;
            cnt_q <= 6'h00;
        end else if (sel_s) begin
            st_q  <= xfc_pkg::ST_IDLE;
            cnt_q <= 6'h00;
        end else if (st_q == xfc_pkg::ST_IDLE) begin
            st_q <= xfc_pkg::ST_CMD;
        end else if (st_q == xfc_pkg::ST_ARMED && smp_ev) begin
            st_q <= xfc_pkg::ST_DROP;
        end else if (st_q == xfc_pkg::ST_DUMMY &&
                     dcnt_q >= 8'(DUMMY_CYC)) begin
            st_q <= xfc_pkg::ST_DOUT;
        end else if (shifting) begin
            sh_q  <= sh_d;
            cnt_q <= cnt_d;
            if (st_q == xfc_pkg::ST_CMD && cnt_d == xfc_pkg::BYTE_BITS) begin
                op_q  <= sh_d[7:0];
                cnt_q <= 6'h00;
                unique case (sh_d[7:0])
                    xfc_pkg::OP_WREN, xfc_pkg::OP_WRDI, xfc_pkg::OP_CLFS:
                        st_q <= xfc_pkg::ST_ARMED;
                    xfc_pkg::OP_RDSR, xfc_pkg::OP_RDFS:
                        st_q <= xfc_pkg::ST_DOUT;
                    xfc_pkg::OP_WRSR, xfc_pkg::OP_WRNV:
                        st_q <= xfc_pkg::ST_DIN;
                    default:
                        st_q <= (is_fast(sh_d[7:0]) ||
                                 sh_d[7:0] == xfc_pkg::OP_RD ||
                                 sh_d[7:0] == xfc_pkg::OP_RD4 ||
                                 sh_d[7:0] == xfc_pkg::OP_RDNV ||
                                 sh_d[7:0] == xfc_pkg::OP_RDV) ?
                                xfc_pkg::ST_ADDR : xfc_pkg::ST_DROP;
                endcase
            end else if (st_q == xfc_pkg::ST_ADDR && cnt_d == addr_bits) begin
                cnt_q <= 6'h00;
                st_q  <= xfc_pkg::ST_DUMMY;
            end else if (st_q == xfc_pkg::ST_DIN &&
                         cnt_d == xfc_pkg::BYTE_BITS) begin
                cnt_q <= 6'h00;
            end
        end
    end

    // dummy clocks, counted on rising edges; plain reads take none
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            dcnt_q <= 8'h00;
        end else if (st_q != xfc_pkg::ST_DUMMY) begin
            dcnt_q <= (op_q == xfc_pkg::OP_RD || op_q == xfc_pkg::OP_RD4) ?
                      8'(DUMMY_CYC) : 8'h00;
        end else if (sck_rise) begin
            dcnt_q <= dcnt_q + 8'h01;
        end
    end

    // register write data bytes, count saturates at three
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            nbyte_q <= 2'h0;
            wdat_q  <= 16'h0000;
        end else if (st_q == xfc_pkg::ST_CMD) begin
            nbyte_q <= 2'h0;
        end else if (shifting && st_q == xfc_pkg::ST_DIN &&
                     cnt_d == xfc_pkg::BYTE_BITS) begin
            wdat_q <= {wdat_q[7:0], sh_d[7:0]};
            if (nbyte_q != 2'h3) begin
                nbyte_q <= nbyte_q + 2'h1;
            end
        end
    end

    // ****************************************
    // write enable latch, error flag, self-timed writes
    // ****************************************
    logic               wr_ok;
    logic               wr_go;
    logic [xfc_pkg::TMR_W-1:0] tmr_q;
    logic               tmr_done;

    // exact byte count with the latch set, else dropped untouched
    assign wr_ok = st_q == xfc_pkg::ST_DIN && wel && !wip &&
                   cnt_q == 6'h00 &&
                   ((op_q == xfc_pkg::OP_WRSR &&
                     nbyte_q == xfc_pkg::WRSR_BYTES) ||
                    (op_q == xfc_pkg::OP_WRNV &&
                     nbyte_q == xfc_pkg::WRNV_BYTES));
    assign wr_go    = sel_rise & wr_ok;
    assign tmr_done = wip && tmr_q == '0;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wel <= 1'b0;
        end else if (tmr_done) begin
            wel <= 1'b0;
        end else if (sel_rise && st_q == xfc_pkg::ST_ARMED) begin
            if (op_q == xfc_pkg::OP_WREN) begin
                wel <= 1'b1;
            end else if (op_q == xfc_pkg::OP_WRDI && !prot_err) begin
                wel <= 1'b0;
            end else if (op_q == xfc_pkg::OP_CLFS) begin
                wel <= 1'b0;
            end
        end
    end

    // set by the array side wins over a clear in the same cycle
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            prot_err <= 1'b0;
        end else if (protect_err_set) begin
            prot_err <= 1'b1;
        end else if (sel_rise && st_q == xfc_pkg::ST_ARMED &&
                     op_q == xfc_pkg::OP_CLFS) begin
            prot_err <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wip   <= 1'b0;
            tmr_q <= '0;
        end else if (wr_go) begin
            wip   <= 1'b1;
            tmr_q <= (op_q == xfc_pkg::OP_WRNV) ?
                     xfc_pkg::TMR_W'(NONVOLATILE_CONFIG_WRITE_TIME_CYC - 1) :
                     xfc_pkg::TMR_W'(TW_CYC - 1);
        end else if (tmr_done) begin
            wip <= 1'b0;
        end else if (wip) begin
            tmr_q <= tmr_q - 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            reg_wr_stb  <= 1'b0;
            reg_wr_nv   <= 1'b0;
            reg_wr_data <= 16'h0000;
        end else begin
            reg_wr_stb <= tmr_done;
            if (wr_go) begin
                reg_wr_nv   <= op_q == xfc_pkg::OP_WRNV;
                reg_wr_data <= wdat_q;
            end
        end
    end

    // ****************************************
    // data output
    // ****************************************
    logic [7:0]         src_byte;
    logic [7:0]         osh_q;
    logic [2:0]         obit_q;
    logic               array_src;
    logic               fetch;

    assign array_src = !(op_q == xfc_pkg::OP_RDSR ||
                         op_q == xfc_pkg::OP_RDFS ||
                         op_q == xfc_pkg::OP_RDNV || op_q == xfc_pkg::OP_RDV);

    always_comb begin
        src_byte = rd_data;
        unique case (op_q)
            xfc_pkg::OP_RDSR: begin
                src_byte = {status_hi, 2'b00};
                src_byte[xfc_pkg::WEL_BIT] = wel;
                src_byte[xfc_pkg::WIP_BIT] = wip;
            end
            xfc_pkg::OP_RDFS: begin
                src_byte = flag_in;
                src_byte[xfc_pkg::READY_BIT] = ~wip;
                src_byte[xfc_pkg::PROT_BIT]  = prot_err;
            end
            xfc_pkg::OP_RDNV: src_byte = nv_cfg | NV_RSVD;
            xfc_pkg::OP_RDV:  src_byte = v_cfg | V_RSVD;
            default:          src_byte = rd_data;
        endcase
    end

    assign fetch = st_q == xfc_pkg::ST_DOUT && drv_ev &&
                   (wide_o || obit_q == 3'h0);

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            octal_out       <= 8'h00;
            octal_oe        <= 8'h00;
            serial_out_line <= 1'b0;
            serial_out_oe   <= 1'b0;
            osh_q           <= 8'h00;
            obit_q          <= 3'h0;
        end else if (st_q != xfc_pkg::ST_DOUT) begin
            octal_oe      <= 8'h00;
            serial_out_oe <= 1'b0;
            obit_q        <= 3'h0;
        end else if (drv_ev) begin
            if (wide_o) begin
                octal_out <= src_byte;
                octal_oe  <= 8'hff;
            end else if (obit_q == 3'h0) begin
                serial_out_line <= src_byte[7];
                serial_out_oe   <= 1'b1;
                osh_q           <= {src_byte[6:0], 1'b0};
                obit_q          <= 3'h7;
            end else begin
                serial_out_line <= osh_q[7];
                osh_q           <= {osh_q[6:0], 1'b0};
                obit_q          <= obit_q - 3'h1;
            end
        end
    end

    // array address: loaded after the address phase, steps per byte
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rd_addr <= 32'h0000_0000;
            rd_req  <= 1'b0;
        end else begin
            rd_req <= fetch & array_src;
            if (shifting && st_q == xfc_pkg::ST_ADDR &&
                cnt_d == addr_bits) begin
                rd_addr <= (addr_bits == xfc_pkg::ADDR4_BITS) ?
                           sh_d : {8'h00, sh_d[23:0]};
            end else if (fetch && array_src) begin
                rd_addr <= rd_addr + 32'h1;
            end
        end
    end

endmodule

// [include/xfc_pkg.sv]
// constants, opcodes and states of the xspi command engine
package xfc_pkg;

    // ****************************************
    // opcodes
    // ****************************************
    localparam logic [7:0] OP_WREN   = 8'h06;
    localparam logic [7:0] OP_WRDI   = 8'h04;
    localparam logic [7:0] OP_CLFS   = 8'h50;
    localparam logic [7:0] OP_RDSR   = 8'h05;
    localparam logic [7:0] OP_RDFS   = 8'h70;
    localparam logic [7:0] OP_RDNV   = 8'hb5;
    localparam logic [7:0] OP_RDV    = 8'h85;
    localparam logic [7:0] OP_WRSR   = 8'h01;
    localparam logic [7:0] OP_WRNV   = 8'hb1;
    localparam logic [7:0] OP_RD     = 8'h03;
    localparam logic [7:0] OP_RD4    = 8'h13;
    localparam logic [7:0] OP_FR     = 8'h0b;
    localparam logic [7:0] OP_FR4    = 8'h0c;
    localparam logic [7:0] OP_OOFR   = 8'h8b;
    localparam logic [7:0] OP_OOFR4  = 8'h7c;
    localparam logic [7:0] OP_OIOFR  = 8'hcb;
    localparam logic [7:0] OP_OIOFR4 = 8'hcc;
    localparam logic [7:0] OP_DOOFR  = 8'h9d;
    localparam logic [7:0] OP_DOIOFR = 8'hfd;

    // ****************************************
    // framing and field layout
    // ****************************************
    localparam logic [5:0] BYTE_BITS   = 6'h08;
    localparam logic [5:0] ADDR3_BITS  = 6'h18;
    localparam logic [5:0] ADDR4_BITS  = 6'h20;
    localparam int         DUMMY_DEF   = 8;
    localparam logic [1:0] WRSR_BYTES  = 2'h1;
    localparam logic [1:0] WRNV_BYTES  = 2'h2;
    localparam int         WIP_BIT     = 0;
    localparam int         WEL_BIT     = 1;
    localparam int         PROT_BIT    = 1;
    localparam int         READY_BIT   = 7;
    localparam logic [7:0] NV_RSVD_DEF = 8'hc0;
    localparam logic [7:0] V_RSVD_DEF  = 8'hc0;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_MHZ   = 25;
    localparam int TMR_W     = 12;
    localparam int TW_NS     = 100000;
    localparam int NONVOLATILE_CONFIG_WRITE_TIME_NS  = 150000;
    localparam int TW_CYC    = (TW_NS * CLK_MHZ + 999) / 1000;
    localparam int NONVOLATILE_CONFIG_WRITE_TIME_CYC = (NONVOLATILE_CONFIG_WRITE_TIME_NS * CLK_MHZ + 999) / 1000;

    // ****************************************
    // decoder states
    // ****************************************
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CMD,
        ST_ADDR,
        ST_DUMMY,
        ST_DIN,
        ST_DOUT,
        ST_ARMED,
        ST_DROP
    } xfc_state_e;

endpackage

// [verilog/xfc_sync.sv]
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/10ps
module xfc_sync #(
    parameter int               WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] meta_q;

    // ****************************************
    // first stage feeds second stage only
    // ****************************************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_q <= RST_VAL;
            dout   <= RST_VAL;
        end else begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end

endmodule

// [tb/xfc_cmd_monitor.sv]
// port assertions for the xspi command engine
`timescale 1ns/10ps
module xfc_cmd_monitor #(
    parameter int TW_CYC    = 20,
    parameter int NONVOLATILE_CONFIG_WRITE_TIME_CYC = 30
) (
    input wire logic       mclk,
    input wire logic       rst_b,
    input wire logic       select_n,
    input wire logic [7:0] octal_oe,
    input wire logic       serial_out_oe,
    input wire logic       wel,
    input wire logic       wip,
    input wire logic       prot_err,
    input wire logic       reg_wr_stb
);
    // ****************************************
    // busy length counter and properties
    // ****************************************
    logic [15:0] busy_q;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            busy_q <= 16'h0000;
        end else begin
            busy_q <= wip ? busy_q + 16'h0001 : 16'h0000;
        end
    end
    default clocking dcb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);
    sequence s_wr_end;
        $fell(wip);
    endsequence
    sequence s_idle;
        select_n [*6];
    endsequence
    a_write_len: assert property (s_wr_end |->
        (busy_q == TW_CYC || busy_q == NONVOLATILE_CONFIG_WRITE_TIME_CYC))
        else $error("register write time wrong");
    a_wel_clr_end: assert property (s_wr_end |-> !wel)
        else $error("latch not cleared at write end");
    a_stb_follows: assert property (s_wr_end |-> ##[0:1] reg_wr_stb)
        else $error("write strobe missing");
    a_wel_set_idle: assert property ($rose(wel) |->
        select_n && $past(select_n))
        else $error("latch set inside a frame");
    a_wip_start: assert property ($rose(wip) |-> select_n && wel)
        else $error("write started without latch");
    a_oe_off_idle: assert property (s_idle |->
        !serial_out_oe && octal_oe == 8'h00)
        else $error("output driven while deselected");
    a_oe_in_frame: assert property ($rose(serial_out_oe) |-> !select_n)
        else $error("output enabled outside frame");
    a_perr_keeps: assert property (prot_err && $past(prot_err) &&
        $past(wel) |-> wel || $fell(wip))
        else $error("latch lost during protection error");
    a_clear_both: assert property ($fell(prot_err) |->
        !wel && select_n)
        else $error("error flag cleared alone");
endmodule
bind xfc_cmd_engine xfc_cmd_monitor #(
    .TW_CYC   (TW_CYC),
    .NONVOLATILE_CONFIG_WRITE_TIME_CYC(NONVOLATILE_CONFIG_WRITE_TIME_CYC)
) u_mon (
    .mclk         (mclk),
    .rst_b        (rst_b),
    .select_n     (select_n),
    .octal_oe     (octal_oe),
    .serial_out_oe(serial_out_oe),
    .wel          (wel),
    .wip          (wip),
    .prot_err     (prot_err),
    .reg_wr_stb   (reg_wr_stb)
);

// [tb/xfc_host_model.sv]
// extended spi host controller model driving the link pins
`timescale 1ns/10ps
module xfc_host_model (
    input  wire logic mclk,
    input  wire logic serial_out_line,
    output logic      select_n,
    output logic      serial_clk,
    output logic      serial_in_line
);
    // ****************************************
    // frame tasks, clock stands low between frames
    // ****************************************
    initial begin
        select_n = 1'b1;
        serial_clk = 1'b0;
        serial_in_line = 1'b0;
    end
    task automatic frame_start();
        @(negedge mclk);
        select_n = 1'b0;
        #160;
    endtask
    task automatic bit_cyc(input logic din, output logic dout);
        serial_in_line = din;
        #160 serial_clk = 1'b1;
        #160 dout = serial_out_line;
        serial_clk = 1'b0;
    endtask
    task automatic frame_end();
        #160 select_n = 1'b1;
        serial_in_line = ~serial_in_line;
        #400;
    endtask
endmodule

// [tb/test_xfc_cmd_engine.sv]
// self-checking bench for the xspi command engine
`timescale 1ns/10ps
module test_xfc_cmd_engine;
    // ****************************************
    // signals, tasks and sequence
    // ****************************************
    localparam logic [7:0] OPS [4] = '{xfc_pkg::OP_RDNV, xfc_pkg::OP_RDV,
                                       xfc_pkg::OP_FR, xfc_pkg::OP_FR4};
    logic        mclk, rst_b, select_n, serial_clk, serial_in_line;
    logic [7:0]  octal_out, octal_oe, flag_in, nv_cfg, v_cfg, rd_data;
    logic        serial_out_line, serial_out_oe, addr4_mode, pe_set;
    logic [5:0]  status_hi;
    logic [31:0] rd_addr;
    logic        rd_req, wel, wip, prot_err, reg_wr_stb, reg_wr_nv;
    logic [15:0] reg_wr_data, rx;
    logic        oct_mode, ddr_en;
    logic [7:0]  oct_lanes;
    int          fail_count, checks_done, req_n;
    xfc_cmd_engine #(.TW_CYC(250), .NONVOLATILE_CONFIG_WRITE_TIME_CYC(300)) u_dut (
        .mclk(mclk), .rst_b(rst_b), .select_n(select_n),
        .serial_clk(serial_clk), .serial_in_line(serial_in_line),
        .octal_in(oct_lanes), .octal_out(octal_out), .octal_oe(octal_oe),
        .serial_out_line(serial_out_line), .serial_out_oe(serial_out_oe),
        .octal_mode(oct_mode), .ddr_mode(ddr_en), .addr4_mode(addr4_mode),
        .status_hi(status_hi), .flag_in(flag_in), .nv_cfg(nv_cfg),
        .v_cfg(v_cfg), .protect_err_set(pe_set), .rd_data(rd_data),
        .rd_addr(rd_addr), .rd_req(rd_req), .wel(wel), .wip(wip),
        .prot_err(prot_err), .reg_wr_stb(reg_wr_stb),
        .reg_wr_nv(reg_wr_nv), .reg_wr_data(reg_wr_data));
    xfc_host_model u_host (.mclk(mclk), .serial_out_line(serial_out_line),
        .select_n(select_n), .serial_clk(serial_clk),
        .serial_in_line(serial_in_line));
    always @(posedge mclk) begin
        if (rd_req === 1'b1) req_n <= req_n + 1;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        if (fail_count == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic frame(input logic [7:0] op, input logic [47:0] tx,
                         input int ntx, input int nrx);
        logic b;
        rx = 16'h0000;
        u_host.frame_start();
        for (int i = 7; i >= 0; i--) u_host.bit_cyc(op[i], b);
        for (int i = 47; i > 47 - ntx; i--) u_host.bit_cyc(tx[i], b);
        for (int i = 0; i < nrx; i++) begin
            u_host.bit_cyc(1'b0, b);
            rx = {rx[14:0], b};
        end
        u_host.frame_end();
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 1000 && wip !== 1'b0; i++) @(negedge mclk);
    endtask
    function automatic logic [7:0] exp_rd(input logic [7:0] op,
                                          input logic wl, input logic wp);
        case (op)
            xfc_pkg::OP_RDSR: exp_rd = {status_hi, wl, wp};
            xfc_pkg::OP_RDFS: exp_rd = {~wp, flag_in[6:2], 1'b0, flag_in[0]};
            xfc_pkg::OP_RDNV: exp_rd = nv_cfg | xfc_pkg::NV_RSVD_DEF;
            xfc_pkg::OP_RDV:  exp_rd = v_cfg | xfc_pkg::V_RSVD_DEF;
            default:          exp_rd = rd_data;
        endcase
    endfunction
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    initial begin
        #1000000;
        fail_count++;
        tally_and_finish();
    end
    initial begin
        logic [7:0]  op;
        logic [15:0] w;
        int          na;
        int          n0;
        logic        b;
        void'($urandom(32'hddf1));
        {rst_b, pe_set, addr4_mode, oct_mode, ddr_en, oct_lanes} = 13'h0;
        {status_hi, flag_in, nv_cfg, v_cfg, rd_data} =
            38'({$urandom, $urandom});
        w = 16'($urandom);
        repeat (3) @(negedge mclk);
        rst_b = 1'b1;
        repeat (4) @(negedge mclk);
        frame(xfc_pkg::OP_WREN, 48'h0, 1, 0);
        check(wel, 1'b0);
        frame(xfc_pkg::OP_WREN, 48'h0, 0, 0);
        check(wel, 1'b1);
        frame(xfc_pkg::OP_RDSR, 48'h0, 0, 16);
        check(rx, {2{exp_rd(xfc_pkg::OP_RDSR, 1'b1, 1'b0)}});
        frame(xfc_pkg::OP_WRDI, 48'h0, 0, 0);
        check(wel, 1'b0);
        frame(xfc_pkg::OP_WREN, 48'h0, 0, 0);
        frame(xfc_pkg::OP_WRSR, {w[7:0], 40'h0}, 8, 0);
        check(wip, 1'b1);
        frame(xfc_pkg::OP_RDSR, 48'h0, 0, 8);
        check(rx[7:0], exp_rd(xfc_pkg::OP_RDSR, 1'b1, 1'b1));
        wait_idle();
        check({wel, reg_wr_data[7:0]}, {1'b0, w[7:0]});
        frame(xfc_pkg::OP_RDFS, 48'h0, 0, 8);
        check(rx[7:0], exp_rd(xfc_pkg::OP_RDFS, 1'b0, 1'b0));
        @(negedge mclk) pe_set = 1'b1;
        @(negedge mclk) pe_set = 1'b0;
        frame(xfc_pkg::OP_WREN, 48'h0, 0, 0);
        frame(xfc_pkg::OP_WRDI, 48'h0, 0, 0);
        check({prot_err, wel}, 2'b11);
        frame(xfc_pkg::OP_CLFS, 48'h0, 0, 0);
        check({prot_err, wel}, 2'b00);
        frame(xfc_pkg::OP_WREN, 48'h0, 0, 0);
        frame(xfc_pkg::OP_WRNV, {w[15:8], 40'h0}, 8, 0);
        check({wip, wel}, 2'b01);
        w = 16'($urandom);
        frame(xfc_pkg::OP_WRNV, {w, 32'h0}, 16, 0);
        check(wip, 1'b1);
        wait_idle();
        check({reg_wr_nv, reg_wr_data}, {1'b1, w});
        for (int m = 0; m < 8; m++) begin
            addr4_mode = m[2];
            op = OPS[m[1:0]];
            na = (addr4_mode || op == xfc_pkg::OP_FR4) ? 32 : 24;
            n0 = req_n;
            frame(op, {w, w, w}, na + 8, 16);
            check(rx, {2{exp_rd(op, 1'b0, 1'b0)}});
            check(rd_addr, (na == 32 ? {w, w} : {8'h00, w, w[15:8]}) +
                  32'(m[1] ? 3 : 0));
            check(req_n - n0, m[1] ? 3 : 0);
        end
        frame(xfc_pkg::OP_WREN, 48'h0, 0, 0);
        @(negedge mclk) rst_b = 1'b0;
        repeat (2) @(negedge mclk);
        check({wel, wip, prot_err, octal_oe}, 11'h000);
        rst_b = 1'b1;
        repeat (4) @(negedge mclk);
        {oct_mode, ddr_en, oct_lanes} = {2'b11, xfc_pkg::OP_RDSR};
        u_host.frame_start();
        u_host.bit_cyc(1'b0, b);
        repeat (4) @(negedge mclk);
        check({octal_oe, octal_out},
              {8'hff, exp_rd(xfc_pkg::OP_RDSR, 1'b0, 1'b0)});
        u_host.frame_end();
        check(octal_oe, 8'h00);
        tally_and_finish();
    end
endmodule
